/* logic/dma_chan_pkg.sv */
// Package: register map, field positions, reset values and states of DMA channel A
package dma_chan_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_MEM_ADDR   = 8'h20;
    localparam logic [7:0] OFS_COUNT      = 8'h24;
    localparam logic [7:0] OFS_IO_ADDR    = 8'h28;
    localparam logic [7:0] OFS_CONTROL    = 8'h2C;
    localparam logic [7:0] OFS_AUX        = 8'h30;
    localparam logic [7:0] OFS_STATUS     = 8'h34;
    localparam logic [7:0] OFS_INT_EN     = 8'h38;
    localparam logic [7:0] OFS_INT_CLR    = 8'h3C;

    // Widths
    localparam int MEM_ADDR_W = 24;
    localparam int COUNT_W    = 16;
    localparam int IO_ADDR_W  = 8;
    localparam int STATUS_W   = 3;

    // Fixed upper byte of the memory address register
    localparam logic [7:0] MEM_ADDR_TOP = 8'hFF;

    // Control register fields
    localparam int CTL_ENABLE   = 7;
    localparam int CTL_SIZE     = 6;
    localparam int CTL_DIR      = 5;
    localparam int CTL_REPEAT   = 4;
    localparam int CTL_INT_EN   = 3;
    localparam int CTL_SEL_HI   = 2;
    localparam int CTL_SEL_LO   = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // Aux register: bit 0 set means memory is source, I/O is destination
    localparam int AUX_MEM_TO_IO = 0;
    localparam logic [0:0] AUX_RESET = 1'h0;

    // Status bits
    localparam int ST_DONE  = 0;
    localparam int ST_END   = 1;
    localparam int ST_FULL  = 2;

    // Activation source codes
    localparam logic [2:0] SEL_SERIAL_TX = 3'h4;
    localparam logic [2:0] SEL_SERIAL_RX = 3'h5;
    localparam logic [2:0] SEL_FULL_A0   = 3'h6;
    localparam logic [2:0] SEL_FULL_A1   = 3'h7;

    // Address steps
    localparam logic [23:0] STEP_BYTE = 24'h000001;
    localparam logic [23:0] STEP_WORD = 24'h000002;

    typedef enum logic [1:0] {
        MODE_IO,
        MODE_REPEAT,
        MODE_IDLE
    } xfer_mode_t;

    typedef enum logic [0:0] {
        ENG_WAIT,
        ENG_BUS
    } eng_state_t;
endpackage : dma_chan_pkg

/* logic/activation_if.sv */
// Interface: activation select, trigger pulse and full-address indication
`timescale 1ns/1ns
interface activation_if;
    logic [2:0] sel;
    logic       fire;
    logic       full_mode;

    modport selector (input sel, output fire, output full_mode);
    modport engine   (output sel, input fire, input full_mode);
endinterface : activation_if

/* logic/activation_select.sv */
// Activation source multiplexer with rising-edge trigger detection
`timescale 1ns/1ns
module activation_select #(
    parameter int TIMER_CH = 4
) (
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    input  wire logic [TIMER_CH-1:0] timer_match_a,
    input  wire logic                serial_tx_empty,
    input  wire logic                serial_rx_full,
    activation_if.selector           act
);
    logic [TIMER_CH-1:0] timer_q;
    logic                tx_q;
    logic                rx_q;
    logic                level;
    logic                level_prev;

    // Pick the selected source level
    always_comb begin
        level = 1'b0;
        level_prev = 1'b0;
        if (act.sel == dma_chan_pkg::SEL_SERIAL_TX) begin
            level = serial_tx_empty;
            level_prev = tx_q;
        end else if (act.sel == dma_chan_pkg::SEL_SERIAL_RX) begin
            level = serial_rx_full;
            level_prev = rx_q;
        end else if (act.sel[2] == 1'b0) begin
            level = timer_match_a[act.sel[1:0]];
            level_prev = timer_q[act.sel[1:0]];
        end
    end

    // Codes 110 and 111 hand the channel to full address mode
    assign act.full_mode = (act.sel == dma_chan_pkg::SEL_FULL_A0) ||
                           (act.sel == dma_chan_pkg::SEL_FULL_A1);

    // Per-source history, so a select change makes no false edge
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            timer_q <= '0;
            tx_q    <= 1'b0;
            rx_q    <= 1'b0;
        end else begin
            timer_q <= timer_match_a;
            tx_q    <= serial_tx_empty;
            rx_q    <= serial_rx_full;
        end
    end

    // One pulse per rising edge of the selected source
    assign act.fire = level && !level_prev && !act.full_mode;
endmodule : activation_select

/* logic/dma_channel_a.sv */
// DMA channel A short address mode: APB registers, trigger handling and transfer engine
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
// How it works
// - Memory address: top byte ones, low 24 RW
// - Short mode: I/O address is other end
// - Full mode: I/O address stored but ignored
// - I/O and idle: 16-bit RW remaining count
// - Select codes 0-5 pick timer/serial triggers
// - Codes 110/111 hand over to full mode
// - Interrupt enable gates enable-bit interrupt
// - Mode from repeat and interrupt enable bits
// - Direction 0: address up by 1 or 2
// - Direction 1: address down by 1 or 2
// - Enable bit 0 blocks all transfers
// - Interrupt while enable bit is 0
module dma_channel_a #(
    parameter int             TIMER_CH = 4,
    parameter logic [15:0]    IO_PAGE  = 16'hFFFF
) (
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [TIMER_CH-1:0] timer_match_a,
    input  wire logic                serial_tx_empty,
    input  wire logic                serial_rx_full,
    output logic                     xfer_req,
    output logic [23:0]              xfer_src_addr,
    output logic [23:0]              xfer_dst_addr,
    output logic                     xfer_word,
    input  wire logic                xfer_done,
    output logic                     full_mode_a,
    output logic                     end_irq,
    output logic                     irq
);
    localparam int AW = dma_chan_pkg::MEM_ADDR_W;
    localparam int CW = dma_chan_pkg::COUNT_W;
    localparam int SW = dma_chan_pkg::STATUS_W;

    // Registers
    logic [AW-1:0]                 mem_addr_q;
    logic [CW-1:0]                 count_q;
    logic [dma_chan_pkg::IO_ADDR_W-1:0] io_addr_q;
    logic [7:0]                    control_q;
    logic                          mem_to_io_q;
    logic [SW-1:0]                 status_q;
    logic [SW-1:0]                 int_en_q;
    logic [31:0]                   prdata_q;
    logic                          slverr_q;
    logic                          xfer_req_q;
    logic [23:0]                   src_q;
    logic [23:0]                   dst_q;
    logic                          word_q;
    dma_chan_pkg::eng_state_t      state_q;

    // Decoded control fields
    logic                          enable_bit;
    logic                          size_bit;
    logic                          dir_bit;
    logic                          repeat_bit;
    logic                          int_en_bit;
    dma_chan_pkg::xfer_mode_t      mode;

    // Bus strobes
    logic                          setup_ph;
    logic                          wr_acc;
    logic                          mapped;
    logic                          wr_mem;
    logic                          wr_count;
    logic                          wr_io;
    logic                          wr_ctl;
    logic                          wr_aux;
    logic                          wr_en;
    logic                          wr_clr;

    // Engine events
    logic                          start;
    logic                          finish;
    logic                          count_zero;
    logic [SW-1:0]                 status_set;
    logic [23:0]                   io_full_addr;

    activation_if act ();

    activation_select #(
        .TIMER_CH        (TIMER_CH)
    ) u_select (
        .sys_clk         (sys_clk),
        .rst_n           (rst_n),
        .timer_match_a   (timer_match_a),
        .serial_tx_empty (serial_tx_empty),
        .serial_rx_full  (serial_rx_full),
        .act             (act.selector)
    );

    // Next memory address after one transfer
    function automatic logic [23:0] step_addr(input logic [23:0] a, input logic word, input logic down);
        logic [23:0] step;
        step = word ? dma_chan_pkg::STEP_WORD : dma_chan_pkg::STEP_BYTE;
        if (down) begin
            step_addr = a - step;
        end else begin
            step_addr = a + step;
        end
    endfunction : step_addr

    // Offset decode, used for both read and write
    function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] ofs);
        is_ofs = (a == ofs);
    endfunction : is_ofs

    // Control field decode
    assign enable_bit = control_q[dma_chan_pkg::CTL_ENABLE];
    assign size_bit   = control_q[dma_chan_pkg::CTL_SIZE];
    assign dir_bit    = control_q[dma_chan_pkg::CTL_DIR];
    assign repeat_bit = control_q[dma_chan_pkg::CTL_REPEAT];
    assign int_en_bit = control_q[dma_chan_pkg::CTL_INT_EN];
    assign act.sel    = control_q[dma_chan_pkg::CTL_SEL_HI:dma_chan_pkg::CTL_SEL_LO];

    // Mode decode from repeat and interrupt enable
    always_comb begin
        if (!repeat_bit) begin
            mode = dma_chan_pkg::MODE_IO;
        end else if (!int_en_bit) begin
            mode = dma_chan_pkg::MODE_REPEAT;
        end else begin
            mode = dma_chan_pkg::MODE_IDLE;
        end
    end

    // APB decode
    assign setup_ph = psel && !penable;
    assign wr_acc   = psel && penable && pwrite;
    assign mapped   = is_ofs(paddr, dma_chan_pkg::OFS_MEM_ADDR) || is_ofs(paddr, dma_chan_pkg::OFS_COUNT) ||
                      is_ofs(paddr, dma_chan_pkg::OFS_IO_ADDR) || is_ofs(paddr, dma_chan_pkg::OFS_CONTROL) ||
                      is_ofs(paddr, dma_chan_pkg::OFS_AUX) || is_ofs(paddr, dma_chan_pkg::OFS_STATUS) ||
                      is_ofs(paddr, dma_chan_pkg::OFS_INT_EN) || is_ofs(paddr, dma_chan_pkg::OFS_INT_CLR);
    assign wr_mem   = wr_acc && is_ofs(paddr, dma_chan_pkg::OFS_MEM_ADDR);
    assign wr_count = wr_acc && is_ofs(paddr, dma_chan_pkg::OFS_COUNT);
    assign wr_io    = wr_acc && is_ofs(paddr, dma_chan_pkg::OFS_IO_ADDR);
    assign wr_ctl   = wr_acc && is_ofs(paddr, dma_chan_pkg::OFS_CONTROL);
    assign wr_aux   = wr_acc && is_ofs(paddr, dma_chan_pkg::OFS_AUX);
    assign wr_en    = wr_acc && is_ofs(paddr, dma_chan_pkg::OFS_INT_EN);
    assign wr_clr   = wr_acc && is_ofs(paddr, dma_chan_pkg::OFS_INT_CLR);

    // Zero-wait slave; read data and error captured in the setup phase
    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = slverr_q;

    // Read data mux, loaded on the setup edge
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prdata_q <= 32'h00000000;
            slverr_q <= 1'b0;
        end else if (setup_ph) begin
            slverr_q <= !mapped;
            prdata_q <= 32'h00000000;
            if (!pwrite) begin
                unique case (paddr)
                    dma_chan_pkg::OFS_MEM_ADDR: prdata_q <= {dma_chan_pkg::MEM_ADDR_TOP, mem_addr_q};
                    dma_chan_pkg::OFS_COUNT:    prdata_q <= {16'h0000, count_q};
                    dma_chan_pkg::OFS_IO_ADDR:  prdata_q <= {24'h000000, io_addr_q};
                    dma_chan_pkg::OFS_CONTROL:  prdata_q <= {24'h000000, control_q};
                    dma_chan_pkg::OFS_AUX:      prdata_q <= {31'h00000000, mem_to_io_q};
                    dma_chan_pkg::OFS_STATUS:   prdata_q <= {29'h00000000, status_q};
                    dma_chan_pkg::OFS_INT_EN:   prdata_q <= {29'h00000000, int_en_q};
                    default:                    prdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    // Engine triggers and completion
    assign start      = (state_q == dma_chan_pkg::ENG_WAIT) && enable_bit && act.fire;
    assign finish     = (state_q == dma_chan_pkg::ENG_BUS) && xfer_done;
    assign count_zero = (count_q == 16'h0001);

    // Engine state
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= dma_chan_pkg::ENG_WAIT;
        end else begin
            unique case (state_q)
                dma_chan_pkg::ENG_WAIT: if (start) begin
                    state_q <= dma_chan_pkg::ENG_BUS;
                end
                dma_chan_pkg::ENG_BUS: if (xfer_done) begin
                    state_q <= dma_chan_pkg::ENG_WAIT;
                end
            endcase
        end
    end

    // I/O address sits in the top page of the address space
    assign io_full_addr = {IO_PAGE, io_addr_q};

    // Bus request with addresses held for the whole transfer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            xfer_req_q <= 1'b0;
            src_q      <= 24'h000000;
            dst_q      <= 24'h000000;
            word_q     <= 1'b0;
        end else if (start) begin
            xfer_req_q <= 1'b1;
            word_q     <= size_bit;
            if (mem_to_io_q) begin
                src_q <= mem_addr_q;
                dst_q <= io_full_addr;
            end else begin
                src_q <= io_full_addr;
                dst_q <= mem_addr_q;
            end
        end else if (finish) begin
            xfer_req_q <= 1'b0;
        end
    end

    assign xfer_req      = xfer_req_q;
    assign xfer_src_addr = src_q;
    assign xfer_dst_addr = dst_q;
    assign xfer_word     = word_q;
    assign full_mode_a   = act.full_mode;

    // Memory address: software write or step after each transfer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mem_addr_q <= '0;
        end else if (wr_mem) begin
            mem_addr_q <= pwdata[AW-1:0];
        end else if (finish) begin
            mem_addr_q <= step_addr(mem_addr_q, size_bit, dir_bit);
        end
    end

    // Transfer counter: software write or count down per transfer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (wr_count) begin
            count_q <= pwdata[CW-1:0];
        end else if (finish) begin
            count_q <= count_q - 16'h0001;
        end
    end

    // I/O address: plain storage, only used in short address mode
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            io_addr_q <= '0;
        end else if (wr_io) begin
            io_addr_q <= pwdata[dma_chan_pkg::IO_ADDR_W-1:0];
        end
    end

    // Control: software write; enable cleared when the count runs out, except in repeat mode
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            control_q <= dma_chan_pkg::CONTROL_RESET;
        end else if (wr_ctl) begin
            control_q <= pwdata[7:0];
        end else if (finish && count_zero && mode != dma_chan_pkg::MODE_REPEAT) begin
            control_q[dma_chan_pkg::CTL_ENABLE] <= 1'b0;
        end
    end

    // Aux direction and interrupt enables
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mem_to_io_q <= dma_chan_pkg::AUX_RESET;
            int_en_q    <= '0;
        end else begin
            if (wr_aux) begin
                mem_to_io_q <= pwdata[dma_chan_pkg::AUX_MEM_TO_IO];
            end
            if (wr_en) begin
                int_en_q <= pwdata[SW-1:0];
            end
        end
    end

    // Sticky event bits: a set in the clear cycle wins
    always_comb begin
        status_set = '0;
        status_set[dma_chan_pkg::ST_DONE] = finish;
        status_set[dma_chan_pkg::ST_END]  = finish && count_zero && mode != dma_chan_pkg::MODE_REPEAT;
        status_set[dma_chan_pkg::ST_FULL] = enable_bit && !act.fire && act.full_mode;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~(wr_clr ? pwdata[SW-1:0] : {SW{1'b0}})) | status_set;
        end
    end

    // Enable-bit interrupt, gated by the interrupt enable bit
    assign end_irq = int_en_bit && !enable_bit;
    assign irq     = |(status_q & int_en_q);
endmodule : dma_channel_a

/* tb/sys_bus_model.sv */
// System bus model: completes each requested transfer after a set latency
`timescale 1ns/1ns
module sys_bus_model (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       xfer_req,
    input  wire logic [3:0] latency,
    output logic            xfer_done
);
    logic [3:0] wait_q;

    // Count cycles of a pending request, then pulse done for one cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wait_q    <= 4'h0;
            xfer_done <= 1'b0;
        end else if (xfer_req && !xfer_done) begin
            if (wait_q >= latency) begin
                xfer_done <= 1'b1;
                wait_q    <= 4'h0;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end else begin
            xfer_done <= 1'b0;
        end
    end
endmodule : sys_bus_model

/* tb/dma_channel_a_checker.sv */
// Checker: port-level properties of DMA channel A
`timescale 1ns/1ns
module dma_channel_a_checker #(
    parameter int TIMER_CH = 4
) (
    input wire logic                sys_clk,
    input wire logic                rst_n,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [7:0]          paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic [TIMER_CH-1:0] timer_match_a,
    input wire logic                serial_tx_empty,
    input wire logic                serial_rx_full,
    input wire logic                xfer_req,
    input wire logic [23:0]         xfer_src_addr,
    input wire logic [23:0]         xfer_dst_addr,
    input wire logic                xfer_word,
    input wire logic                xfer_done,
    input wire logic                full_mode_a,
    input wire logic                end_irq,
    input wire logic                irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Bus phase qualifiers, decoded write data and trigger sources
    wire logic setup_c = psel && !penable;
    wire logic ctl_wr = psel && penable && pwrite && paddr == dma_chan_pkg::OFS_CONTROL;
    wire logic bad_a = paddr[1:0] != 2'h0 || paddr < 8'h20 || paddr > 8'h3C;
    wire logic full_w = pwdata[2] && pwdata[1];
    wire logic eirq_w = pwdata[3] && !pwdata[7];
    wire logic [TIMER_CH+1:0] src_v = {serial_rx_full, serial_tx_empty, timer_match_a};

    property p_req_hold;
        xfer_req && !xfer_done |=> xfer_req && $stable(xfer_src_addr) && $stable(xfer_dst_addr) && $stable(xfer_word);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request moved before done");
    property p_req_drop;
        xfer_req && xfer_done |=> !xfer_req;
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("request kept after done");
    property p_unmapped;
        setup_c && bad_a |=> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_mem_top;
        setup_c && !pwrite && paddr == dma_chan_pkg::OFS_MEM_ADDR |=> prdata[31:24] == dma_chan_pkg::MEM_ADDR_TOP;
    endproperty
    a_mem_top: assert property (p_mem_top) else $error("address top byte not ones");
    property p_full_mode;
        ctl_wr |=> full_mode_a == $past(full_w);
    endproperty
    a_full_mode: assert property (p_full_mode) else $error("full mode flag wrong");
    property p_full_no_req;
        full_mode_a && !xfer_req |=> !xfer_req;
    endproperty
    a_full_no_req: assert property (p_full_no_req) else $error("short transfer in full mode");
    property p_end_irq;
        ctl_wr |=> end_irq == $past(eirq_w);
    endproperty
    a_end_irq: assert property (p_end_irq) else $error("end interrupt level wrong");
    property p_src_edge;
        $rose(xfer_req) |-> |($past(src_v) & ~$past(src_v, 2));
    endproperty
    a_src_edge: assert property (p_src_edge) else $error("request without source edge");

    // Main scenarios reached
    c_xfer: cover property (xfer_req && xfer_done);
    c_err: cover property (psel && penable && pslverr);
    c_end: cover property (end_irq && irq);
endmodule : dma_channel_a_checker

bind dma_channel_a dma_channel_a_checker #(.TIMER_CH(TIMER_CH)) chk_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_match_a(timer_match_a),
    .serial_tx_empty(serial_tx_empty), .serial_rx_full(serial_rx_full), .xfer_req(xfer_req),
    .xfer_src_addr(xfer_src_addr), .xfer_dst_addr(xfer_dst_addr), .xfer_word(xfer_word),
    .xfer_done(xfer_done), .full_mode_a(full_mode_a), .end_irq(end_irq), .irq(irq)
);

/* tb/dma_channel_a_short_address_tb_top.sv */
// Testbench top: registers, triggers, stepping and interrupts of DMA channel A
`timescale 1ns/1ns
module dma_channel_a_short_address_tb_top;
    localparam logic [15:0] IO_PAGE = 16'hFFFF;
    localparam logic [7:0] CTL = dma_chan_pkg::OFS_CONTROL, CNT = dma_chan_pkg::OFS_COUNT;
    localparam logic [7:0] MA = dma_chan_pkg::OFS_MEM_ADDR, IEN = dma_chan_pkg::OFS_INT_EN;
    logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic [5:0]  srcs;
    logic        xfer_req, xfer_word, xfer_done, full_mode_a, end_irq, irq, rd_err, got, cap_word;
    logic [23:0] xfer_src_addr, xfer_dst_addr, cap_src, cap_dst;
    logic [3:0]  latency;
    int          err_total, samples_checked;

    dma_channel_a #(.TIMER_CH(4), .IO_PAGE(IO_PAGE)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_match_a(srcs[3:0]), .serial_tx_empty(srcs[4]), .serial_rx_full(srcs[5]),
        .xfer_req(xfer_req), .xfer_src_addr(xfer_src_addr), .xfer_dst_addr(xfer_dst_addr),
        .xfer_word(xfer_word), .xfer_done(xfer_done), .full_mode_a(full_mode_a),
        .end_irq(end_irq), .irq(irq)
    );
    // Far-side bus completing each transfer
    sys_bus_model bus_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .xfer_req(xfer_req), .latency(latency), .xfer_done(xfer_done)
    );

    // Clock generator, 8 ns period
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask : chk

    // One APB transfer: setup, then access until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd_q = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            report_and_stop();
        end
    endtask : apb

    task automatic w(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : w

    task automatic r(input logic [7:0] a, input string nm, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd_q);
    endtask : r

    // Raise one source, note any request, then wait for the bus to finish
    task automatic run(input int code);
        int n;
        got = 1'b0;
        @(posedge sys_clk);
        srcs <= 6'h01 << code;
        for (n = 0; n < 8; n++) begin
            @(posedge sys_clk);
            if (xfer_req === 1'b1 && got === 1'b0) begin
                got = 1'b1;
                cap_src = xfer_src_addr;
                cap_dst = xfer_dst_addr;
                cap_word = xfer_word;
            end
        end
        srcs <= 6'h00;
        for (n = 0; n < 20 && xfer_req !== 1'b0; n++) @(posedge sys_clk);
        if (xfer_req !== 1'b0) begin
            err_total++;
            report_and_stop();
        end
    endtask : run

    task automatic s_regs();
        r(CTL, "control reset", 32'h0);
        w(MA, 32'h00ABCDEF);
        r(MA, "memory address", 32'hFFABCDEF);
        w(CNT, 32'h00012345);
        r(CNT, "count", 32'h2345);
        r(8'h40, "unmapped read", 32'h0);
        chk("unmapped error", 32'h1, 32'(rd_err));
    endtask : s_regs

    task automatic s_select();
        w(dma_chan_pkg::OFS_IO_ADDR, 32'h155);
        w(dma_chan_pkg::OFS_AUX, 32'h0);
        for (int c = 0; c < 6; c++) begin
            w(MA, 32'h100);
            w(CNT, 32'h5);
            w(CTL, 32'h80 | 32'(c));
            run((c + 1) % 6);
            chk("other source", 32'h0, 32'(got));
            run(c);
            chk("selected source", 32'h1, 32'(got));
            chk("io end source", {8'h00, IO_PAGE, 8'h55}, 32'(cap_src));
            chk("memory end dest", 32'h100, 32'(cap_dst));
        end
    endtask : s_select

    task automatic s_step();
        logic [31:0] st;
        w(dma_chan_pkg::OFS_AUX, 32'h1);
        for (int i = 0; i < 4; i++) begin
            w(MA, 32'h1000);
            w(CNT, 32'h5);
            w(CTL, 32'h80 | (32'(i) << 5));
            latency <= 4'(3 * i);
            run(0);
            st = i[1] ? 32'h2 : 32'h1;
            chk("word size", 32'(i[1]), 32'(cap_word));
            chk("memory end source", 32'h1000, 32'(cap_src));
            r(MA, "step", i[0] ? 32'hFF001000 - st : 32'hFF001000 + st);
            r(CNT, "count down", 32'h4);
        end
    endtask : s_step

    task automatic s_end();
        w(IEN, 32'h3);
        w(CNT, 32'h2);
        w(CTL, 32'h88);
        run(0);
        r(CTL, "enable kept", 32'h88);
        chk("no end irq", 32'h0, 32'(end_irq));
        run(0);
        r(CTL, "enable cleared", 32'h08);
        r(dma_chan_pkg::OFS_STATUS, "status", 32'h3);
        chk("end irq", 32'h1, 32'(end_irq));
        run(0);
        chk("disabled", 32'h0, 32'(got));
        w(IEN, 32'h0);
        #1;
        chk("irq masked", 32'h0, 32'(irq));
        w(IEN, 32'h3);
        #1;
        chk("irq raised", 32'h1, 32'(irq));
        w(dma_chan_pkg::OFS_INT_CLR, 32'h3);
        #1;
        chk("irq cleared", 32'h0, 32'(irq));
        w(CTL, 32'h0);
        #1;
        chk("end irq off", 32'h0, 32'(end_irq));
    endtask : s_end

    task automatic s_modes();
        w(CNT, 32'h1);
        w(CTL, 32'h90);
        run(0);
        r(CTL, "repeat enable", 32'h90);
        r(CNT, "repeat count", 32'h0);
        w(CNT, 32'h1);
        w(CTL, 32'h98);
        run(0);
        r(CTL, "idle end", 32'h18);
        for (int c = 6; c < 8; c++) begin
            w(CTL, 32'h80 | 32'(c));
            #1;
            chk("full flag", 32'h1, 32'(full_mode_a));
            run(0);
            chk("no short xfer", 32'h0, 32'(got));
        end
        w(dma_chan_pkg::OFS_IO_ADDR, 32'h3C);
        r(dma_chan_pkg::OFS_IO_ADDR, "io in full mode", 32'h3C);
    endtask : s_modes

    // Reset, then the scenarios in turn
    initial begin
        err_total = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        srcs = 6'h00;
        latency = 4'h1;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        s_regs();
        s_select();
        s_step();
        s_end();
        s_modes();
        report_and_stop();
    end
endmodule : dma_channel_a_short_address_tb_top
